// >>> core/nfcds_top.sv
// Flash command interface, write state machine, read path and die select
// What this block does
// - Reset leaves the part in asynchronous page reads.
// - Burst reads start only after the host writes the read configuration.
// - Burst data is launched on edges of the host-supplied clock.
// - A wait output marks burst data not yet valid.
// - Program and erase start only through command sequences.
// - The write state machine times program and erase on its own.
// - Status shows completion and flags errors of the operation.
// - Each erase clears exactly the one addressed block.
// - A running erase can pause for reads or programs elsewhere.
// - A running program can pause for reads of other locations.
// - Each program writes one whole 16-bit word.
// - Program and erase are refused while program supply is low.
// - Lock and unlock take effect at once.
// - Four predefined spaces can each become one-time programmable.
// - Two dies share one chip select; an address bit picks one.
// - Select low and pick bit low: lower die responds.
// - Select low and pick bit high: upper die responds.
`timescale 1ns/10ps
module nfcds_top import nfcds_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int BLK_W = 4,
  parameter logic DIE_ID = 1'b0,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic chipSelN, // Shared chip select pin
  input wire logic diePick, // Die pick address pin
  input wire logic writeEnN, // Write strobe pin
  input wire logic outEnN, // Output enable pin
  input wire logic burstClk, // Host burst clock pin
  input wire logic vppLow, // Supply at or below lockout
  input wire logic [ADDR_W-1:0] addrIn, // Address pins
  input wire logic [DATA_W-1:0] dataIn, // Data pins, input side
  input wire logic [DATA_W-1:0] arrayRData, // Array read word
  output logic [DATA_W-1:0] dataOut, // Data pins, output side
  output logic dataOeN, // Low while driving data
  output logic waitOut, // High while burst data invalid
  output logic lowerDieSel, // Lower die responds
  output logic upperDieSel, // Upper die responds
  output logic [ADDR_W-1:0] arrayRdAddr, // Array read address
  output logic [ADDR_W-1:0] arrayOpAddr, // Program/erase address
  output logic [DATA_W-1:0] arrayWData, // Program word
  output logic arrayProgStb, // Program one word
  output logic arrayEraseStb, // Erase one block
  output logic [7:0] statusOut, // Status register
  output logic syncMode // Burst reads enabled
);
  localparam int NBLK = 1 << BLK_W;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pinMeta, pinSync;
  logic [ADDR_W+DATA_W-1:0] busMeta, busSync;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pinMeta <= PIN_RST;
      pinSync <= PIN_RST;
      {busMeta, busSync} <= '0;
    end else begin
      pinMeta <= {chipSelN, diePick, writeEnN, outEnN, burstClk, vppLow};
      pinSync <= pinMeta;
      busMeta <= {addrIn, dataIn};
      busSync <= busMeta;
    end
  end
  logic csS, dieS, weS, oeS, clkS, vppLowS;
  logic [ADDR_W-1:0] addrS, burstAddr;
  logic [DATA_W-1:0] dataS;
  assign {csS, dieS, weS, oeS, clkS, vppLowS} = pinSync;
  assign {addrS, dataS} = busSync;
  logic weP, oeP, clkP;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {weP, oeP, clkP} <= 3'b110;
    end else begin
      {weP, oeP, clkP} <= {weS, oeS, clkS};
    end
  end
  logic selected, weRise, oeFall, clkRise, bursting;
  assign selected = !csS && (dieS == DIE_ID);
  assign weRise = selected && weS && !weP;
  assign oeFall = selected && !oeS && oeP;
  assign clkRise = clkS && !clkP;
  // ----------------------------------------------------------------
  // Die select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {lowerDieSel, upperDieSel} <= 2'b00;
    end else begin
      lowerDieSel <= !csS && !dieS;
      upperDieSel <= !csS && dieS;
    end
  end
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  nfcds_pend_t pend;
  nfcds_ws_t state;
  logic [7:0] cmd, progCnt;
  logic [BLK_W-1:0] blk, eraseBlk;
  logic [1:0] otpIdx;
  logic [NBLK-1:0] locked;
  logic [OTP_SPACES-1:0] otpCfg, otpUsed;
  logic [3:0] latency, latCnt;
  assign cmd = dataS[7:0];
  assign blk = addrS[ADDR_W-1 -: BLK_W];
  assign otpIdx = blk[1:0];
  logic idleCmd, cmdSusp, cmdResume, cmdClr, cmdLock, cmdUnlock, cmdCfg, readStat, nested;
  logic blkOtp, progReq, eraseReq, progRefuse, eraseRefuse, progGo, eraseGo, otpPend;
  assign idleCmd = weRise && pend == PD_NONE;
  assign cmdSusp = idleCmd && cmd == C_SUSPEND;
  assign cmdResume = idleCmd && cmd == C_CONFIRM;
  assign cmdClr = idleCmd && cmd == C_CLR_STAT;
  assign cmdLock = weRise && pend == PD_LOCK && cmd == C_LOCK;
  assign cmdUnlock = weRise && pend == PD_LOCK && cmd == C_CONFIRM;
  assign cmdCfg = weRise && pend == PD_LOCK && cmd == C_CFG;
  assign blkOtp = blk < BLK_W'(OTP_SPACES);
  // A program accepted during erase suspend must avoid the erased block
  assign progReq = weRise && pend == PD_PROG && (state == WS_IDLE || state == WS_ESUSP);
  assign eraseReq = weRise && pend == PD_ERASE && cmd == C_CONFIRM && state == WS_IDLE;
  assign progRefuse = vppLowS || locked[blk] || (blkOtp && otpCfg[otpIdx] && otpUsed[otpIdx])
    || (state == WS_ESUSP && blk == eraseBlk);
  assign eraseRefuse = vppLowS || locked[blk] || (blkOtp && otpCfg[otpIdx]);
  assign progGo = progReq && !progRefuse;
  assign eraseGo = eraseReq && !eraseRefuse;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend <= PD_NONE;
    end else if (weRise) begin
      if (pend != PD_NONE) begin
        pend <= PD_NONE;
      end else begin
        case (cmd)
          C_PROG_SETUP: pend <= PD_PROG;
          C_ERASE_SETUP: pend <= PD_ERASE;
          C_LOCK_SETUP: pend <= PD_LOCK;
          default: pend <= PD_NONE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Configuration, locks and one-time spaces
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncMode <= SYNC_RST;
      latency <= LAT_RST;
      locked <= {NBLK{LOCK_RST}};
      {otpCfg, otpUsed} <= '0;
      otpPend <= 1'b0;
    end else begin
      if (cmdCfg) begin
        syncMode <= addrS[CFG_SYNC_BIT];
        latency <= addrS[3:0];
      end
      if (cmdLock) locked[blk] <= 1'b1;
      if (cmdUnlock) locked[blk] <= 1'b0;
      if (weRise) otpPend <= (pend == PD_NONE) && cmd == C_OTP_SETUP;
      if (weRise && otpPend && cmd == C_CONFIRM && blkOtp) otpCfg[otpIdx] <= 1'b1;
      // Once configured, a space accepts a single program only
      if (progGo && blkOtp && otpCfg[otpIdx]) otpUsed[otpIdx] <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Write state machine
  // ----------------------------------------------------------------
  logic [$clog2(ERASE_CYCLES+1)-1:0] eraseCnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= WS_IDLE;
      progCnt <= '0;
      eraseCnt <= '0;
      nested <= 1'b0;
      eraseBlk <= '0;
      arrayOpAddr <= '0;
      arrayWData <= '0;
      {arrayProgStb, arrayEraseStb} <= 2'b00;
    end else begin
      arrayProgStb <= progGo;
      arrayEraseStb <= eraseGo;
      if (progGo) begin
        arrayOpAddr <= addrS;
        arrayWData <= dataS;
      end else if (eraseGo) begin
        arrayOpAddr <= addrS;
        eraseBlk <= blk;
      end
      case (state)
        WS_IDLE, WS_ESUSP: begin
          if (progGo) begin
            state <= WS_PROG;
            progCnt <= PROG_CYC - 8'h01;
            nested <= (state == WS_ESUSP);
          end else if (eraseGo) begin
            state <= WS_ERASE;
            eraseCnt <= ($bits(eraseCnt))'(ERASE_CYCLES - 1);
          end else if (state == WS_ESUSP && cmdResume) begin
            state <= WS_ERASE;
          end
        end
        WS_PROG: begin
          // Supply dropping mid-operation aborts with an error
          if (vppLowS || progCnt == '0) state <= nested ? WS_ESUSP : WS_IDLE;
          else if (cmdSusp) state <= WS_PSUSP;
          else progCnt <= progCnt - 8'h01;
        end
        WS_PSUSP: if (cmdResume) state <= WS_PROG;
        WS_ERASE: begin
          if (vppLowS || eraseCnt == '0) state <= WS_IDLE;
          else if (cmdSusp) state <= WS_ESUSP;
          else eraseCnt <= eraseCnt - 1'b1;
        end
        default: state <= WS_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  logic errE, errP, errV, errL, setE, setP, setV, setL;
  assign setV = ((progReq || eraseReq) || state == WS_PROG || state == WS_ERASE) && vppLowS;
  assign setL = (progReq || eraseReq) && locked[blk];
  assign setP = (progReq && progRefuse) || (state == WS_PROG && vppLowS);
  assign setE = (eraseReq && eraseRefuse) || (state == WS_ERASE && vppLowS);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {errE, errP, errV, errL} <= 4'h0;
      statusOut <= 8'h00;
    end else begin
      // A new error in the clearing cycle survives the clear
      errE <= (errE && !cmdClr) || setE;
      errP <= (errP && !cmdClr) || setP;
      errV <= (errV && !cmdClr) || setV;
      errL <= (errL && !cmdClr) || setL;
      statusOut <= 8'h00;
      statusOut[ST_READY] <= state != WS_PROG && state != WS_ERASE;
      statusOut[ST_ESUSP] <= state == WS_ESUSP || nested && state != WS_IDLE
        && state != WS_ERASE;
      statusOut[ST_PSUSP] <= state == WS_PSUSP;
      statusOut[ST_EERR] <= errE;
      statusOut[ST_PERR] <= errP;
      statusOut[ST_VPP] <= errV;
      statusOut[ST_LOCK] <= errL;
    end
  end
  // ----------------------------------------------------------------
  // Read path: asynchronous page reads or clocked bursts
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      readStat <= 1'b0;
    end else if (progGo || eraseGo || cmdSusp || (idleCmd && cmd == C_READ_STAT)) begin
      readStat <= 1'b1;
    end else if (idleCmd && cmd == C_READ_ARRAY) begin
      readStat <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dataOut <= '0;
      dataOeN <= 1'b1;
      {waitOut, bursting} <= 2'b00;
      latCnt <= '0;
      burstAddr <= '0;
      arrayRdAddr <= '0;
    end else begin
      dataOeN <= !(selected && !oeS);
      arrayRdAddr <= bursting ? burstAddr : addrS;
      if (!selected || oeS) begin
        bursting <= 1'b0;
        waitOut <= 1'b0;
      end else if (oeFall && syncMode && !readStat) begin
        bursting <= 1'b1;
        waitOut <= 1'b1;
        latCnt <= latency;
        burstAddr <= addrS;
      end else if (bursting) begin
        // Burst words advance only on host clock edges
        if (clkRise) begin
          if (latCnt != 4'h0) begin
            latCnt <= latCnt - 4'h1;
          end else begin
            waitOut <= 1'b0;
            dataOut <= arrayRData;
            burstAddr <= burstAddr + 1'b1;
          end
        end
      end else begin
        dataOut <= readStat ? {8'h00, statusOut} : arrayRData;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_burstOpen;
    oeFall && syncMode && !readStat;
  endsequence
  sequence s_eraseRun;
    state == WS_ERASE && !vppLowS && eraseCnt != '0;
  endsequence
  a_reset_async: assert property (!$past(rst_n) |-> !syncMode && !bursting)
    else $error("not in async reads after reset");
  a_sync_by_cfg: assert property ($rose(syncMode) |-> $past(cmdCfg))
    else $error("burst mode without config write");
  a_burst_edge: assert property (bursting && $changed(dataOut) |-> $past(clkRise))
    else $error("burst data moved off host clock edge");
  a_wait_open: assert property (s_burstOpen |=> waitOut && bursting)
    else $error("wait not raised at burst start");
  a_prog_done: assert property (state == WS_PROG && progCnt == '0 |=> ##1 statusOut[ST_READY])
    else $error("ready not shown after program");
  a_erase_one: assert property (arrayEraseStb |-> state == WS_ERASE ##1 !arrayEraseStb)
    else $error("erase strobe not a single pulse");
  a_erase_susp: assert property (s_eraseRun ##0 cmdSusp |=> state == WS_ESUSP)
    else $error("erase did not suspend");
  a_prog_susp: assert property (state == WS_PROG && progCnt != '0 && !vppLowS && cmdSusp
    |=> state == WS_PSUSP)
    else $error("program did not suspend");
  a_vpp_refuse: assert property (arrayProgStb || arrayEraseStb |-> !$past(vppLowS))
    else $error("operation started under supply lockout");
  a_lock_now: assert property (cmdLock |=> locked[$past(blk)])
    else $error("lock did not apply at once");
  a_die_lower: assert property (!csS && !dieS |=> lowerDieSel && !upperDieSel)
    else $error("lower die not selected");
  a_die_upper: assert property (!csS && dieS |=> upperDieSel && !lowerDieSel)
    else $error("upper die not selected");
  a_die_none: assert property (csS |=> !lowerDieSel && !upperDieSel ##0 dataOeN)
    else $error("die responds without chip select");
endmodule

// >>> core/nfcds_pkg.sv
// Shared constants and types of the flash control and die select block
package nfcds_pkg;
  localparam int DATA_W = 16;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] C_PROG_SETUP = 8'h40;
  localparam logic [7:0] C_ERASE_SETUP = 8'h20;
  localparam logic [7:0] C_CONFIRM = 8'hD0;
  localparam logic [7:0] C_SUSPEND = 8'hB0;
  localparam logic [7:0] C_READ_STAT = 8'h70;
  localparam logic [7:0] C_CLR_STAT = 8'h50;
  localparam logic [7:0] C_READ_ARRAY = 8'hFF;
  localparam logic [7:0] C_LOCK_SETUP = 8'h60;
  localparam logic [7:0] C_LOCK = 8'h01;
  localparam logic [7:0] C_CFG = 8'h03;
  localparam logic [7:0] C_OTP_SETUP = 8'hC0;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_READY = 7;
  localparam int ST_ESUSP = 6;
  localparam int ST_EERR = 5;
  localparam int ST_PERR = 4;
  localparam int ST_VPP = 3;
  localparam int ST_PSUSP = 2;
  localparam int ST_LOCK = 1;
  // ----------------------------------------------------------------
  // Config field positions, reset values, counts
  // ----------------------------------------------------------------
  localparam int CFG_SYNC_BIT = 4;
  localparam logic SYNC_RST = 1'b0;
  localparam logic [3:0] LAT_RST = 4'h3;
  localparam logic LOCK_RST = 1'b1;
  localparam int OTP_SPACES = 4;
  localparam logic [5:0] PIN_RST = 6'h2D;
  localparam logic [7:0] PROG_CYC = 8'h10;
  localparam int ERASE_CYC = 4000;
  typedef enum logic [2:0] {
    WS_IDLE = 3'b000, WS_PROG = 3'b001, WS_PSUSP = 3'b101,
    WS_ERASE = 3'b010, WS_ESUSP = 3'b110
  } nfcds_ws_t;
  typedef enum logic [1:0] {
    PD_NONE = 2'b00, PD_PROG = 2'b01, PD_ERASE = 2'b11, PD_LOCK = 2'b10
  } nfcds_pend_t;
endpackage

// >>> tb/nfcds_host.sv
// Host-side bus model: command writes, reads and the burst clock
`timescale 1ns/10ps
module nfcds_host import nfcds_pkg::*; (
  input wire logic clk_sys, // System clock
  output logic chipSelN, // Shared chip select
  output logic diePick, // Die pick address
  output logic writeEnN, // Write strobe
  output logic outEnN, // Output enable
  output logic burstClk, // Burst clock, still outside bursts
  output logic [15:0] addrIn, // Address pins
  output logic [DATA_W-1:0] dataIn // Data pins
);
  initial begin
    chipSelN = 1'b1;
    diePick = 1'b0;
    writeEnN = 1'b1;
    outEnN = 1'b1;
    burstClk = 1'b0;
    addrIn = 16'h0000;
    dataIn = 16'h0000;
  end
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // Address and data held well past the strobe rise; the pins are synced
  task automatic wr(input logic [15:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    #1;
    chipSelN = 1'b0;
    diePick = 1'b0;
    addrIn = a;
    dataIn = d;
    writeEnN = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    writeEnN = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chipSelN = 1'b1;
    addrIn = ~a;
    dataIn = ~d;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rdOn(input logic [15:0] a, input logic pick);
    @(posedge clk_sys);
    #1;
    chipSelN = 1'b0;
    diePick = pick;
    addrIn = a;
    outEnN = 1'b0;
  endtask
  task automatic rdOff();
    @(posedge clk_sys);
    #1;
    outEnN = 1'b1;
    chipSelN = 1'b1;
    addrIn = ~addrIn;
  endtask
  // Period 64 ns; edges kept clear of system clock rising edges
  task automatic burst(input int n);
    repeat (n) begin
      #17 burstClk = 1'b1;
      #32 burstClk = 1'b0;
      #15;
    end
  endtask
endmodule

// >>> tb/nfcds_tb_top.sv
// Testbench of the flash control and die select block
`timescale 1ns/10ps
module nfcds_tb_top import nfcds_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic vppLow = 1'b0;
  logic chipSelN, diePick, writeEnN, outEnN, burstClk;
  logic [15:0] addrIn, arrayRdAddr, arrayOpAddr, lastOp;
  logic [DATA_W-1:0] dataIn, dataOut, arrayWData, lastW;
  logic [DATA_W-1:0] arrayRData = 16'h0000;
  logic dataOeN, waitOut, lowerDieSel, upperDieSel, arrayProgStb, arrayEraseStb, syncMode;
  logic [7:0] statusOut;
  int failures = 0;
  int compares = 0;
  int progCnt = 0;
  int eraseCnt = 0;
  always #2 clk_sys = ~clk_sys;
  nfcds_host host (.clk_sys(clk_sys), .chipSelN(chipSelN), .diePick(diePick),
    .writeEnN(writeEnN), .outEnN(outEnN), .burstClk(burstClk), .addrIn(addrIn),
    .dataIn(dataIn));
  nfcds_top #(.ERASE_CYCLES(80)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .chipSelN(chipSelN), .diePick(diePick), .writeEnN(writeEnN), .outEnN(outEnN),
    .burstClk(burstClk), .vppLow(vppLow), .addrIn(addrIn), .dataIn(dataIn),
    .arrayRData(arrayRData), .dataOut(dataOut), .dataOeN(dataOeN), .waitOut(waitOut),
    .lowerDieSel(lowerDieSel), .upperDieSel(upperDieSel), .arrayRdAddr(arrayRdAddr),
    .arrayOpAddr(arrayOpAddr), .arrayWData(arrayWData), .arrayProgStb(arrayProgStb),
    .arrayEraseStb(arrayEraseStb), .statusOut(statusOut), .syncMode(syncMode));
  // --------------------------------------------------------------
  // Array model and strobe monitor
  // --------------------------------------------------------------
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'hA5C3;
  endfunction
  always @(posedge clk_sys) begin
    arrayRData <= pat(arrayRdAddr);
    if (arrayProgStb === 1'b1) begin
      progCnt++;
      lastOp = arrayOpAddr;
      lastW = arrayWData;
    end
    if (arrayEraseStb === 1'b1) begin
      eraseCnt++;
      lastOp = arrayOpAddr;
    end
  end
  // --------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic waitReady(input int lim);
    int n;
    n = 0;
    while (statusOut[ST_READY] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk("ready", 16'(statusOut[ST_READY]), 16'h0001);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    repeat (4) @(posedge clk_sys);
    chk("status", 16'(statusOut), 16'h0080);
    chk("syncMode", 16'(syncMode), 16'h0000);
    chk("dieSels", {14'h0000, lowerDieSel, upperDieSel}, 16'h0000);
  endtask
  task automatic t_dieSel();
    host.rdOn(16'h0100, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk("lowSel", {14'h0000, lowerDieSel, upperDieSel}, 16'h0002);
    chk("asyncData", dataOut, pat(16'h0100));
    chk("asyncOe", {15'h0000, dataOeN}, 16'h0000);
    host.rdOn(16'h0100, 1'b1);
    repeat (8) @(posedge clk_sys);
    chk("highSel", {14'h0000, lowerDieSel, upperDieSel}, 16'h0001);
    chk("otherDieOe", {15'h0000, dataOeN}, 16'h0001);
    host.rdOff();
    repeat (8) @(posedge clk_sys);
    chk("noSel", {14'h0000, lowerDieSel, upperDieSel}, 16'h0000);
  endtask
  task automatic t_prog();
    host.wr(16'h5000, 16'h0060);
    host.wr(16'h5000, 16'h00D0);
    host.wr(16'h5123, 16'h0040);
    host.wr(16'h5123, 16'hBEEF);
    chk("progCount", 16'(progCnt), 16'h0001);
    chk("progWord", lastW, 16'hBEEF);
    chk("progAddr", lastOp, 16'h5123);
    waitReady(40);
    chk("progStatus", 16'(statusOut), 16'h0080);
    // Relock and program straight away: must be refused
    host.wr(16'h5000, 16'h0060);
    host.wr(16'h5000, 16'h0001);
    host.wr(16'h5200, 16'h0040);
    host.wr(16'h5200, 16'h1234);
    chk("lockedProg", 16'(progCnt), 16'h0001);
    chk("lockErr", 16'(statusOut[ST_LOCK]), 16'h0001);
    host.wr(16'h0000, 16'h0050);
    chk("cleared", 16'(statusOut), 16'h0080);
  endtask
  task automatic t_vpp();
    host.wr(16'h5000, 16'h0060);
    host.wr(16'h5000, 16'h00D0);
    #1 vppLow = 1'b1;
    host.wr(16'h5300, 16'h0040);
    host.wr(16'h5300, 16'h5555);
    host.wr(16'h5000, 16'h0020);
    host.wr(16'h5000, 16'h00D0);
    chk("vppProg", 16'(progCnt), 16'h0001);
    chk("vppErase", 16'(eraseCnt), 16'h0000);
    chk("vppErr", 16'(statusOut[ST_VPP]), 16'h0001);
    #1 vppLow = 1'b0;
    host.wr(16'h0000, 16'h0050);
  endtask
  task automatic t_erase();
    host.wr(16'h5000, 16'h0020);
    host.wr(16'h5000, 16'h00D0);
    chk("eraseCount", 16'(eraseCnt), 16'h0001);
    chk("eraseBlk", 16'(lastOp[15:12]), 16'h0005);
    host.wr(16'h0000, 16'h00B0);
    chk("eraseSusp", 16'(statusOut[ST_ESUSP]), 16'h0001);
    // Program another block while the erase is paused
    host.wr(16'h7000, 16'h0060);
    host.wr(16'h7000, 16'h00D0);
    host.wr(16'h7010, 16'h0040);
    host.wr(16'h7010, 16'h4321);
    chk("suspProg", 16'(progCnt), 16'h0002);
    chk("suspWord", lastW, 16'h4321);
    waitReady(40);
    chk("backInSusp", 16'(statusOut), 16'h00C0);
    host.wr(16'h0000, 16'h00FF);
    host.rdOn(16'h7010, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk("suspRead", dataOut, pat(16'h7010));
    host.rdOff();
    host.wr(16'h0000, 16'h00D0);
    chk("resumed", 16'(statusOut[ST_ESUSP]), 16'h0000);
    waitReady(200);
    chk("eraseStatus", 16'(statusOut), 16'h0080);
    chk("eraseOnce", 16'(eraseCnt), 16'h0001);
  endtask
  task automatic t_otp();
    host.wr(16'h2000, 16'h00C0);
    host.wr(16'h2000, 16'h00D0);
    host.wr(16'h2000, 16'h0060);
    host.wr(16'h2000, 16'h00D0);
    host.wr(16'h2010, 16'h0040);
    host.wr(16'h2010, 16'h1111);
    chk("otpFirst", 16'(progCnt), 16'h0003);
    waitReady(40);
    // A configured space takes one program only
    host.wr(16'h2020, 16'h0040);
    host.wr(16'h2020, 16'h2222);
    chk("otpSecond", 16'(progCnt), 16'h0003);
    host.wr(16'h0000, 16'h0070);
    host.rdOn(16'h2000, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk("statRead", dataOut, 16'h0090);
    host.rdOff();
  endtask
  task automatic t_burst();
    host.wr(16'h0000, 16'h00FF);
    host.rdOn(16'h2000, 1'b0);
    host.burst(2);
    chk("asyncWait", 16'(waitOut), 16'h0000);
    host.rdOff();
    // Latency two, burst enable in address bit 4
    host.wr(16'h0012, 16'h0060);
    host.wr(16'h0012, 16'h0003);
    chk("syncOn", 16'(syncMode), 16'h0001);
    host.rdOn(16'h2040, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk("waitStart", 16'(waitOut), 16'h0001);
    host.burst(2);
    chk("waitLat", 16'(waitOut), 16'h0001);
    host.burst(1);
    chk("waitDone", 16'(waitOut), 16'h0000);
    chk("burst0", dataOut, pat(16'h2040));
    host.burst(1);
    chk("burst1", dataOut, pat(16'h2041));
    repeat (40) @(posedge clk_sys);
    chk("burstHold", dataOut, pat(16'h2041));
    host.rdOff();
    repeat (8) @(posedge clk_sys);
    chk("burstEnd", 16'(waitOut), 16'h0000);
    chk("burstOe", {15'h0000, dataOeN}, 16'h0001);
  endtask
  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_dieSel();
    t_prog();
    t_vpp();
    t_erase();
    t_otp();
    t_burst();
    wrap_up();
  end
  // Whole sequence needs well under 20 us
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
